/* mri_host.sv */
`timescale 1ns/1ps
module mri_host
   import mri_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe,
   output logic o_rvalid,
   output logic [7:0] o_rdata
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
      o_rvalid = 1'b0;
      o_rdata = 8'h00;
   end
   task automatic hp(input int n);
      repeat (n) @(negedge i_clk);
   endtask : hp
   // sda moves only well inside scl low
   task automatic bit_io(input logic b, output logic s);
      hp(3);
      o_sda_oe = ~b;
      hp(7);
      o_scl = 1'b1;
      hp(10);
      s = i_sda;
      o_scl = 1'b0;
   endtask : bit_io
   // sda falls only once scl has stood high; also a repeated start
   task automatic start;
      hp(3);
      o_sda_oe = 1'b0;
      hp(7);
      o_scl = 1'b1;
      hp(10);
      o_sda_oe = 1'b1;
      hp(10);
      o_scl = 1'b0;
   endtask : start
   task automatic stop;
      hp(3);
      o_sda_oe = 1'b1;
      hp(7);
      o_scl = 1'b1;
      hp(10);
      o_sda_oe = 1'b0;
      hp(10);
   endtask : stop
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
         inout logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(1'b1, s);
      ok = ok & ~s;
   endtask : xfer
   task automatic head(input logic [7:0] ofs, output logic ok);
      logic [7:0] r;
      ok = 1'b1;
      start();
      xfer({MRI_SLAVE_ADDR_DEFAULT, 1'b0}, r, ok);
      xfer(ofs, r, ok);
   endtask : head
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d,
         output logic ok);
      logic [7:0] r;
      head(ofs, ok);
      xfer(d, r, ok);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] ofs, output logic ok);
      logic [7:0] r;
      logic na;
      head(ofs, ok);
      start();
      xfer({MRI_SLAVE_ADDR_DEFAULT, 1'b1}, r, ok);
      na = 1'b1;
      xfer(8'hff, r, na);
      stop();
      o_rdata = r;
      o_rvalid = 1'b1;
      @(negedge i_clk);
      o_rvalid = 1'b0;
   endtask : rd
endmodule : mri_host

/* mri_monitor_regs.sv */
`timescale 1ns/1ps
// How it works
// - after reset the interrupt pin stays released until software rewrites the configuration.
// - software enables the pin by writing configuration with clear bit 2 low and enable bit 1 high.
// - with enable set but clear still high, events are recorded in status while the pin stays released.
// - the maker identifier at 0x3e is a fixed read-only byte that writes cannot change.
// - the revision at 0x3f shows stepping in bits 3..0 and version in bits 7..4.
// - reset loads configuration at 0x40 with 0x25.
// - reset clears interrupt status 0x41, interrupt mask 0x43 and status copy 0x4c.
// - addresses 0x42, 0x44, 0x47 and 0x4a are reserved with no function behind them.
// - setting the clear bit releases the pin and leaves interrupt status untouched.
module mri_monitor_regs
   import mri_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = MRI_SLAVE_ADDR_DEFAULT,
   parameter logic [7:0] MAKER_ID = MRI_MAKER_ID_DEFAULT,
   parameter logic [3:0] VERSION = MRI_VERSION_DEFAULT,
   parameter logic [3:0] STEPPING = MRI_STEPPING_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic [7:0] i_event,
   output logic o_int_n_out,
   output logic o_int_n_oe,
   output logic [7:0] o_config,
   output logic [7:0] o_int_status
);

   logic scl_f;
   logic sda_f;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   mri_state_type state_reg;
   mri_state_type state_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic [7:0] pointer_reg;
   logic [7:0] pointer_next;
   logic is_read_reg;
   logic is_read_next;
   logic nack_reg;
   logic nack_next;
   logic sda_drive_reg;
   logic sda_drive_next;
   logic wr_stb;
   logic rd_stb;

   logic [7:0] conf_reg;
   logic [7:0] mask_reg;
   logic [7:0] status_reg;
   logic [7:0] status_copy_reg;
   logic [7:0] status_clr;
   logic int_drive_reg;
   logic int_request;
   logic [7:0] rd_data;

   mri_sync #(
      .RESET_VAL(MRI_LINE_IDLE)
   ) u_scl_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pin(i_scl),
      .o_level(scl_f)
   );

   mri_sync #(
      .RESET_VAL(MRI_LINE_IDLE)
   ) u_sda_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pin(i_sda_in),
      .o_level(sda_f)
   );

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         scl_prev_reg <= MRI_LINE_IDLE;
         sda_prev_reg <= MRI_LINE_IDLE;
      end else begin
         scl_prev_reg <= scl_f;
         sda_prev_reg <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_prev_reg;
   assign scl_fall = ~scl_f & scl_prev_reg;
   assign bus_start = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
   assign bus_stop = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

   // read mux: unmapped and reserved addresses give zero
   always_comb begin
      unique case (pointer_reg)
         MRI_OFS_MAKER_IDENTIFIER: rd_data = MAKER_ID;
         MRI_OFS_PART_REVISION: begin
            rd_data = 8'h00;
            rd_data[MRI_REV_STEPPING_LSB +: 4] = STEPPING;
            rd_data[MRI_REV_VERSION_LSB +: 4] = VERSION;
         end
         MRI_OFS_DEVICE_CONFIGURATION: rd_data = conf_reg;
         MRI_OFS_INTERRUPT_STATUS: rd_data = status_reg;
         MRI_OFS_INTERRUPT_MASK: rd_data = mask_reg;
         MRI_OFS_INTERRUPT_STATUS_COPY: rd_data = status_copy_reg;
         default: rd_data = 8'h00;
      endcase
   end

   // serial slave sequencing
   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      pointer_next = pointer_reg;
      is_read_next = is_read_reg;
      nack_next = nack_reg;
      sda_drive_next = sda_drive_reg;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      if (bus_stop) begin
         state_next = MRI_ST_IDLE;
         sda_drive_next = 1'b0;
      end else if (bus_start) begin
         state_next = MRI_ST_ADDR;
         bit_cnt_next = 4'h0;
         sda_drive_next = 1'b0;
      end else begin
         unique case (state_reg)
            MRI_ST_IDLE: begin
               sda_drive_next = 1'b0;
            end
            MRI_ST_ADDR, MRI_ST_CMD, MRI_ST_WDATA: begin
               if (scl_rise && bit_cnt_reg != MRI_BYTE_BITS) begin
                  shift_next = {shift_reg[6:0], sda_f};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == MRI_BYTE_BITS) begin
                  sda_drive_next = 1'b1;
                  if (state_reg == MRI_ST_ADDR) begin
                     if (shift_reg[7:1] == SLAVE_ADDR) begin
                        is_read_next = shift_reg[0];
                        state_next = MRI_ST_ADDR_ACK;
                     end else begin
                        sda_drive_next = 1'b0;
                        state_next = MRI_ST_IDLE;
                     end
                  end else if (state_reg == MRI_ST_CMD) begin
                     pointer_next = shift_reg;
                     state_next = MRI_ST_CMD_ACK;
                  end else begin
                     // every data byte is acknowledged, even when ignored
                     wr_stb = 1'b1;
                     state_next = MRI_ST_WDATA_ACK;
                  end
               end
            end
            MRI_ST_ADDR_ACK, MRI_ST_CMD_ACK, MRI_ST_WDATA_ACK: begin
               if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (state_reg == MRI_ST_ADDR_ACK && is_read_reg) begin
                     tx_next = rd_data;
                     sda_drive_next = ~rd_data[7];
                     rd_stb = 1'b1;
                     state_next = MRI_ST_RDATA;
                  end else begin
                     sda_drive_next = 1'b0;
                     state_next = (state_reg == MRI_ST_ADDR_ACK) ?
                                  MRI_ST_CMD : MRI_ST_WDATA;
                  end
               end
            end
            MRI_ST_RDATA: begin
               if (scl_fall) begin
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg + 4'h1 == MRI_BYTE_BITS) begin
                     sda_drive_next = 1'b0;
                     state_next = MRI_ST_RACK;
                  end else begin
                     tx_next = {tx_reg[6:0], 1'b0};
                     sda_drive_next = ~tx_reg[6];
                  end
               end
            end
            MRI_ST_RACK: begin
               if (scl_rise) begin
                  nack_next = sda_f;
               end else if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (nack_reg) begin
                     state_next = MRI_ST_IDLE;
                  end else begin
                     tx_next = rd_data;
                     sda_drive_next = ~rd_data[7];
                     rd_stb = 1'b1;
                     state_next = MRI_ST_RDATA;
                  end
               end
            end
            default: begin
               sda_drive_next = 1'b0;
               state_next = MRI_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= MRI_ST_IDLE;
         bit_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         is_read_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         is_read_reg <= is_read_next;
         nack_reg <= nack_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pointer_reg <= 8'h00;
      end else begin
         pointer_reg <= pointer_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sda_drive_reg <= 1'b0;
      end else begin
         sda_drive_reg <= sda_drive_next;
      end
   end

   // writable registers; read-only and reserved offsets ignore writes
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         conf_reg <= MRI_RST_DEVICE_CONFIGURATION;
      end else if (wr_stb && pointer_reg == MRI_OFS_DEVICE_CONFIGURATION) begin
         conf_reg <= shift_reg;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mask_reg <= MRI_RST_INTERRUPT_MASK;
      end else if (wr_stb && pointer_reg == MRI_OFS_INTERRUPT_MASK) begin
         mask_reg <= shift_reg;
      end
   end

   // status clears when read; an event in the same cycle wins
   assign status_clr = (rd_stb && pointer_reg == MRI_OFS_INTERRUPT_STATUS) ?
                       8'hff : 8'h00;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         status_reg <= MRI_RST_INTERRUPT_STATUS;
      end else begin
         // recorded whatever the pin enables say
         status_reg <= (status_reg & ~status_clr) | i_event;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         status_copy_reg <= MRI_RST_INTERRUPT_STATUS_COPY;
      end else begin
         status_copy_reg <= status_reg;
      end
   end

   // pin pulled low only with enable set and clear low
   assign int_request = conf_reg[MRI_CONF_INT_ENABLE_BIT] &
                        ~conf_reg[MRI_CONF_INT_CLEAR_BIT] &
                        (|(status_reg & ~mask_reg));

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         int_drive_reg <= 1'b0;
      end else begin
         int_drive_reg <= int_request;
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe = sda_drive_reg;
   assign o_int_n_out = 1'b0;
   assign o_int_n_oe = int_drive_reg;
   assign o_config = conf_reg;
   assign o_int_status = status_reg;

endmodule : mri_monitor_regs

/* mri_monitor_regs_props.sv */
`timescale 1ns/1ps
module mri_monitor_regs_props (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_scl,
   input wire logic [7:0] i_event,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_int_n_out,
   input wire logic o_int_n_oe,
   input wire logic [7:0] o_config,
   input wire logic [7:0] o_int_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   reset_val_a:
   assert property ($past(i_srst) |-> o_config == 8'h25
      && o_int_status == 8'h00 && !o_int_n_oe) else $error("reset values");
   drive_low_a:
   assert property (!o_sda_out && !o_int_n_out) else $error("pin level");
   pin_off_a:
   assert property (o_int_n_oe |-> $past(o_config[1] && !o_config[2]))
      else $error("pin without enable");
   pin_gate_a:
   assert property ((!o_config[1] || o_config[2]) |=> !o_int_n_oe)
      else $error("pin not released");
   event_set_a:
   assert property (i_event != 8'h00 |=>
      (o_int_status & $past(i_event)) == $past(i_event))
      else $error("event not recorded");
   clear_keep_a:
   assert property ($rose(o_config[2]) && $past(i_event) == 8'h00
      |-> o_int_status == $past(o_int_status)) else $error("status lost");
   cfg_change_a:
   assert property (!$stable(o_config) |-> !i_scl && !$past(i_scl))
      else $error("config moved off bus");
   sda_change_a:
   assert property (!$stable(o_sda_oe) |-> !i_scl)
      else $error("sda moved with scl high");
endmodule : mri_monitor_regs_props
bind mri_monitor_regs mri_monitor_regs_props u_mri_monitor_regs_props (
   .i_clk, .i_srst, .i_scl, .i_event, .o_sda_out, .o_sda_oe,
   .o_int_n_out, .o_int_n_oe, .o_config, .o_int_status);

/* mri_monitor_regs_test.sv */
`timescale 1ns/1ps
module mri_monitor_regs_test;
   import mri_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] ev = 8'h00;
   logic scl, hoe, doe, dout, int_out, int_oe, rvalid, ok;
   logic [7:0] cfg, st, rdata, e;
   logic [7:0] exp_q [$];
   logic [7:0] ro_ofs [8] = '{8'h3e, 8'h3f, 8'h41, 8'h42, 8'h44, 8'h47,
      8'h4a, 8'h4c};
   logic [7:0] ro_val [8] = '{MRI_MAKER_ID_DEFAULT,
      {MRI_VERSION_DEFAULT, MRI_STEPPING_DEFAULT}, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   integer seed = 32'hfda6090b;
   // pulled-up open-drain data line
   wire logic sda = !(hoe || (doe && !dout));
   always #50 clk = ~clk;
   mri_monitor_regs u_mri_monitor_regs (.i_clk(clk), .i_srst(srst),
      .i_scl(scl), .i_sda_in(sda), .o_sda_out(dout), .o_sda_oe(doe),
      .i_event(ev), .o_int_n_out(int_out), .o_int_n_oe(int_oe),
      .o_config(cfg), .o_int_status(st));
   mri_host u_mri_host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(hoe), .o_rvalid(rvalid), .o_rdata(rdata));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic check_reg(string nm, logic [7:0] x, logic [7:0] g);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask : check_reg
   task automatic check_pin(string nm, logic x, logic g);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s expected %b seen %b", nm, x, g);
      end
   endtask : check_pin
   task automatic wr_ok(logic [7:0] o, logic [7:0] d);
      u_mri_host.wr(o, d, ok);
      check_pin("write ack", 1'b1, ok);
      repeat (2) @(negedge clk);
   endtask : wr_ok
   task automatic rd_exp(logic [7:0] o, logic [7:0] x);
      exp_q.push_back(x);
      u_mri_host.rd(o, ok);
      check_pin("read ack", 1'b1, ok);
   endtask : rd_exp
   task automatic pulse(logic [7:0] v);
      ev = v;
      @(negedge clk);
      ev = 8'h00;
      repeat (3) @(negedge clk);
   endtask : pulse
   always @(posedge clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_reg("unasked read", 8'h00, 8'hxx);
         end else begin
            check_reg("read data", exp_q.pop_front(), rdata);
         end
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         report_and_stop();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      check_reg("config", MRI_RST_DEVICE_CONFIGURATION, cfg);
      check_pin("int pin", 1'b0, int_oe);
      rd_exp(MRI_OFS_DEVICE_CONFIGURATION, 8'h25);
      rd_exp(MRI_OFS_INTERRUPT_MASK, MRI_RST_INTERRUPT_MASK);
      for (int i = 0; i < 8; i++) begin
         wr_ok(ro_ofs[i], 8'($random(seed)));
         rd_exp(ro_ofs[i], ro_val[i]);
      end
      wr_ok(8'h00, 8'($random(seed)));
      rd_exp(8'h00, 8'h00);
      check_reg("config", 8'h25, cfg);
      e = 8'($random(seed)) | 8'h01;
      pulse(e);
      check_pin("int pin", 1'b0, int_oe);
      wr_ok(MRI_OFS_DEVICE_CONFIGURATION, 8'h06);
      check_reg("status", e, st);
      check_pin("int pin", 1'b0, int_oe);
      rd_exp(MRI_OFS_INTERRUPT_STATUS_COPY, e);
      wr_ok(MRI_OFS_DEVICE_CONFIGURATION, 8'h02);
      check_pin("int pin", 1'b1, int_oe);
      wr_ok(MRI_OFS_DEVICE_CONFIGURATION, 8'h06);
      check_pin("int pin", 1'b0, int_oe);
      check_reg("status", e, st);
      wr_ok(MRI_OFS_INTERRUPT_MASK, 8'hff);
      wr_ok(MRI_OFS_DEVICE_CONFIGURATION, 8'h02);
      check_pin("int pin", 1'b0, int_oe);
      rd_exp(MRI_OFS_INTERRUPT_MASK, 8'hff);
      rd_exp(MRI_OFS_INTERRUPT_STATUS, e);
      rd_exp(MRI_OFS_INTERRUPT_STATUS, 8'h00);
      wr_ok(MRI_OFS_INTERRUPT_MASK, 8'h00);
      pulse(e);
      check_pin("int pin", 1'b1, int_oe);
      check_pin("int level", 1'b0, int_out);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      check_reg("config", 8'h25, cfg);
      check_reg("status", 8'h00, st);
      check_pin("int pin", 1'b0, int_oe);
      check_reg("reads left", 8'h00, 8'(exp_q.size()));
      report_and_stop();
   end
endmodule : mri_monitor_regs_test

/* mri_pkg.sv */
package mri_pkg;

   // register offsets on the serial management bus
   localparam logic [7:0] MRI_OFS_MAKER_IDENTIFIER = 8'h3e;
   localparam logic [7:0] MRI_OFS_PART_REVISION = 8'h3f;
   localparam logic [7:0] MRI_OFS_DEVICE_CONFIGURATION = 8'h40;
   localparam logic [7:0] MRI_OFS_INTERRUPT_STATUS = 8'h41;
   localparam logic [7:0] MRI_OFS_RESERVED_A = 8'h42;
   localparam logic [7:0] MRI_OFS_INTERRUPT_MASK = 8'h43;
   localparam logic [7:0] MRI_OFS_RESERVED_B = 8'h44;
   localparam logic [7:0] MRI_OFS_RESERVED_C = 8'h47;
   localparam logic [7:0] MRI_OFS_RESERVED_D = 8'h4a;
   localparam logic [7:0] MRI_OFS_INTERRUPT_STATUS_COPY = 8'h4c;

   // values after reset
   localparam logic [7:0] MRI_RST_DEVICE_CONFIGURATION = 8'h25;
   localparam logic [7:0] MRI_RST_INTERRUPT_STATUS = 8'h00;
   localparam logic [7:0] MRI_RST_INTERRUPT_MASK = 8'h00;
   localparam logic [7:0] MRI_RST_INTERRUPT_STATUS_COPY = 8'h00;

   // configuration field positions
   localparam int MRI_CONF_INT_ENABLE_BIT = 1;
   localparam int MRI_CONF_INT_CLEAR_BIT = 2;

   // part revision field positions
   localparam int MRI_REV_STEPPING_LSB = 0;
   localparam int MRI_REV_VERSION_LSB = 4;

   // identity values: arbitrary, chosen for this design
   localparam logic [7:0] MRI_MAKER_ID_DEFAULT = 8'h5a;
   localparam logic [3:0] MRI_VERSION_DEFAULT = 4'h3;
   localparam logic [3:0] MRI_STEPPING_DEFAULT = 4'h1;

   // serial bus slave address, plain default
   localparam logic [6:0] MRI_SLAVE_ADDR_DEFAULT = 7'h2c;

   // bits in one serial byte
   localparam logic [3:0] MRI_BYTE_BITS = 4'h8;

   // idle level of a released bus line
   localparam logic MRI_LINE_IDLE = 1'b1;

   typedef enum logic [3:0] {
      MRI_ST_IDLE = 4'b0000,
      MRI_ST_ADDR = 4'b0001,
      MRI_ST_ADDR_ACK = 4'b0010,
      MRI_ST_CMD = 4'b0011,
      MRI_ST_CMD_ACK = 4'b0100,
      MRI_ST_WDATA = 4'b0101,
      MRI_ST_WDATA_ACK = 4'b0110,
      MRI_ST_RDATA = 4'b0111,
      MRI_ST_RACK = 4'b1000
   } mri_state_type;

endpackage : mri_pkg

/* mri_sync.sv */
`timescale 1ns/1ps
module mri_sync
   import mri_pkg::*;
#(
   parameter logic RESET_VAL = MRI_LINE_IDLE
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pin,
   output logic o_level
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once the second and third stage agree
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         level_reg <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         level_reg <= s3_reg;
      end
   end

   assign o_level = level_reg;

endmodule : mri_sync
